// ### rtl/sbcmsc_pkg.sv
// Constants for the mode and supply control register bank.
package sbcmsc_pkg;

    // ----------------------------------------
    // Serial frame layout
    // ----------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 7;
    localparam int ACC_BIT = 7;
    localparam int DATA_LSB = 8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [6:0] OFS_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] OFS_HW0 = 7'h02;
    localparam logic [6:0] OFS_WDOG = 7'h03;
    localparam logic [6:0] OFS_BUS0 = 7'h04;
    localparam logic [6:0] OFS_INT_WAKE = 7'h06;
    localparam logic [6:0] OFS_EXT_WAKE = 7'h07;
    localparam logic [6:0] OFS_WAKE_LEVEL = 7'h08;
    localparam logic [6:0] OFS_BUS3 = 7'h0B;
    localparam logic [6:0] OFS_TIMER = 7'h0C;
    localparam logic [6:0] OFS_HW1 = 7'h0E;
    localparam logic [6:0] OFS_HW2 = 7'h0F;
    localparam logic [6:0] OFS_GPIO_CFG = 7'h17;
    localparam logic [6:0] OFS_PWM_CFG = 7'h18;
    localparam logic [6:0] OFS_PWM_FREQ = 7'h1C;
    localparam logic [6:0] OFS_HW3 = 7'h1D;
    localparam logic [6:0] OFS_SYS_STAT_LO = 7'h1E;
    localparam logic [6:0] OFS_SYS_STAT_HI = 7'h1F;

    // ----------------------------------------
    // Field positions and masks
    // ----------------------------------------
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int AUX_HI = 4;
    localparam int AUX_LO = 3;
    localparam int OV_ACT_BIT = 2;
    localparam int THR_HI = 1;
    localparam int THR_LO = 0;
    localparam logic [7:0] MODE_WR_MASK = 8'hDF;
    localparam logic [7:0] MODE_RESTART_KEEP = 8'h03;
    localparam int SRST_CFG_BIT = 6;
    localparam int FAIL_FORCE_BIT = 5;
    localparam int PUMP_EN_BIT = 2;
    localparam int WD_CNT_BIT = 0;
    localparam logic [7:0] HW0_WR_MASK = 8'h65;
    localparam logic [7:0] HW0_RESTART_KEEP = 8'h45;
    localparam int LOCK0_BIT = 3;
    localparam int LOCK1_BIT = 0;

    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] HW0_RESET = 8'h00;
    localparam logic [7:0] GEN_RESET = 8'h00;
    localparam logic [1:0] AUX_OFF = 2'h0;
    localparam logic [1:0] AUX_NORMAL = 2'h1;
    localparam logic [1:0] AUX_NORM_STOP = 2'h2;
    localparam logic [1:0] AUX_ALWAYS = 2'h3;

    typedef enum logic [1:0] {
        SBCMSC_NORMAL = 2'b00,
        SBCMSC_SLEEP = 2'b01,
        SBCMSC_STOP = 2'b10,
        SBCMSC_SOFT_RESET = 2'b11
    } sbcmsc_mode_t;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int SOFT_RST_LOW_NS = 10000;
    localparam int SOFT_RST_LOW_CYC = (SOFT_RST_LOW_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### rtl/sbcmsc_regs.sv
// Mode and supply control register bank behind a 16-bit serial port.
`timescale 1ns/1ps

module sbcmsc_regs
    import sbcmsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic spi_clk_i,
    input wire logic spi_sel_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic dev_mode_i,
    input wire logic restart_entry_i,
    input wire logic restart_active_i,
    input wire logic failsafe_active_i,
    input wire logic init_active_i,
    input wire logic overtemp_i,
    input wire logic overvolt_i,
    input wire logic overvolt_flag_clear_i,
    input wire logic failure_flag_i,
    input wire logic fail_pin_is_fail_out_i,
    input wire logic wd_trigger_fail_i,
    input wire logic spi_fail_clear_i,
    output logic [1:0] chip_mode_o,
    output logic [1:0] main_supply_reset_threshold_o,
    output logic aux_supply_on_o,
    output logic main_supply_overvolt_flag_o,
    output logic restart_request_o,
    output logic spi_fail_flag_o,
    output logic reset_output_pin_n_o,
    output logic fail_output_pin_o,
    output logic charge_pump_enable_o
);

    // ----------------------------------------
    // Pin synchronisers and serial framing
    // ----------------------------------------
    logic [1:0] sclk_s_q, sel_s_q, mosi_s_q, dev_s_q;
    logic sclk_d1_q, sel_d1_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] rx_q;
    logic [7:0] tx_q;
    logic sclk_rise, sclk_fall, frame_end, wr_commit;
    logic [6:0] addr;
    logic [7:0] wdata, rd_byte;

    always_ff @(posedge clk_i) begin
        sclk_s_q <= {sclk_s_q[0], spi_clk_i};
        sel_s_q <= {sel_s_q[0], spi_sel_n_i};
        mosi_s_q <= {mosi_s_q[0], spi_mosi_i};
        dev_s_q <= {dev_s_q[0], dev_mode_i};
        sclk_d1_q <= sclk_s_q[1];
        sel_d1_q <= sel_s_q[1];
    end

    assign sclk_rise = sclk_s_q[1] & ~sclk_d1_q & ~sel_s_q[1];
    assign sclk_fall = ~sclk_s_q[1] & sclk_d1_q & ~sel_s_q[1];
    assign frame_end = sel_s_q[1] & ~sel_d1_q;
    assign addr = rx_q[ADDR_BITS-1:0];
    assign wdata = rx_q[FRAME_BITS-1:DATA_LSB];
    assign wr_commit = frame_end & (bit_cnt_q == 5'(FRAME_BITS)) & rx_q[ACC_BIT];

    always_ff @(posedge clk_i) begin
        if (srst_i || sel_s_q[1]) begin
            bit_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
        end else if (sclk_rise && bit_cnt_q < 5'(FRAME_BITS)) begin
            rx_q[bit_cnt_q[3:0]] <= mosi_s_q[1];
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Old content is latched once the address is known, before any commit.
    always_ff @(posedge clk_i) begin
        if (srst_i || sel_s_q[1]) begin
            tx_q <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (sclk_fall) begin
            if (bit_cnt_q == 5'(DATA_LSB)) begin
                spi_miso_o <= rd_byte[0];
                tx_q <= {1'b0, rd_byte[7:1]};
            end else begin
                spi_miso_o <= tx_q[0];
                tx_q <= {1'b0, tx_q[7:1]};
            end
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] mode_q, hw0_q;
    logic [7:0] gen_q [0:31];
    logic mode_wr, hw0_wr, gen_wr, soft_rst, stop_to_sleep, stop_to_norm;
    logic lock0, lock1, gen_mapped;
    logic [1:0] por_cnt_q;

    assign lock0 = gen_q[OFS_HW1[4:0]][LOCK0_BIT];
    assign lock1 = gen_q[OFS_HW2[4:0]][LOCK1_BIT];
    assign mode_wr = wr_commit & (addr == OFS_MODE_SUPPLY);
    assign hw0_wr = wr_commit & (addr == OFS_HW0);
    assign soft_rst = mode_wr & (wdata[MODE_HI:MODE_LO] == SBCMSC_SOFT_RESET);
    assign stop_to_sleep = mode_q[MODE_HI:MODE_LO] == SBCMSC_STOP
        && wdata[MODE_HI:MODE_LO] == SBCMSC_SLEEP;
    assign stop_to_norm = mode_q[MODE_HI:MODE_LO] == SBCMSC_STOP
        && wdata[MODE_HI:MODE_LO] == SBCMSC_NORMAL;

    always_comb begin
        case (addr)
            OFS_WDOG, OFS_BUS0, OFS_INT_WAKE, OFS_EXT_WAKE, OFS_WAKE_LEVEL,
            OFS_BUS3, OFS_TIMER, OFS_HW1, OFS_HW2, OFS_GPIO_CFG,
            OFS_PWM_CFG, OFS_PWM_FREQ, OFS_HW3, OFS_SYS_STAT_LO,
            OFS_SYS_STAT_HI: gen_mapped = 1'b1;
            default: gen_mapped = 1'b0;
        endcase
    end
    assign gen_wr = wr_commit & gen_mapped;

    always_comb begin
        if (addr == OFS_MODE_SUPPLY) begin
            rd_byte = mode_q & MODE_WR_MASK;
        end else if (addr == OFS_HW0) begin
            rd_byte = hw0_q & HW0_WR_MASK;
        end else if (gen_mapped) begin
            rd_byte = gen_q[addr[4:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Development mode level is caught once it has passed the synchroniser.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            por_cnt_q <= 2'h0;
        end else if (por_cnt_q != 2'h3) begin
            por_cnt_q <= por_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_q <= MODE_RESET;
        end else if (restart_entry_i) begin
            mode_q <= mode_q & MODE_RESTART_KEEP;
        end else if (soft_rst) begin
            mode_q <= MODE_RESET;
        end else if (mode_wr && !stop_to_sleep) begin
            if (stop_to_norm) begin
                mode_q[MODE_HI:MODE_LO] <= SBCMSC_NORMAL;
            end else begin
                mode_q <= wdata & MODE_WR_MASK;
            end
            if (overtemp_i) begin
                mode_q[AUX_HI:AUX_LO] <= AUX_OFF;
            end
        end else if (overtemp_i) begin
            mode_q[AUX_HI:AUX_LO] <= AUX_OFF;
        end else if (por_cnt_q == 2'h2 && dev_s_q[1]) begin
            mode_q[AUX_HI:AUX_LO] <= AUX_ALWAYS;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hw0_q <= HW0_RESET;
        end else if (restart_entry_i) begin
            hw0_q <= hw0_q & HW0_RESTART_KEEP;
        end else if (soft_rst) begin
            hw0_q[FAIL_FORCE_BIT] <= 1'b0;
            hw0_q[WD_CNT_BIT] <= 1'b0;
            if (!lock1) begin
                hw0_q[SRST_CFG_BIT] <= 1'b0;
            end
            if (!lock0) begin
                hw0_q[PUMP_EN_BIT] <= 1'b0;
            end
        end else if (hw0_wr) begin
            hw0_q[FAIL_FORCE_BIT] <= wdata[FAIL_FORCE_BIT];
            hw0_q[WD_CNT_BIT] <= wdata[WD_CNT_BIT];
            if (!lock1) begin
                hw0_q[SRST_CFG_BIT] <= wdata[SRST_CFG_BIT];
            end
            if (!lock0) begin
                hw0_q[PUMP_EN_BIT] <= wdata[PUMP_EN_BIT];
            end
        end
    end

    // Other registers are plain storage, except that a write can set but not clear LOCK1_BIT in HW2; lock bits survive a soft reset.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 32; i++) begin
                gen_q[i] <= GEN_RESET;
            end
        end else if (soft_rst) begin
            for (int i = 0; i < 32; i++) begin
                if (i == int'(OFS_HW1)) begin
                    gen_q[i] <= gen_q[i] & (8'h01 << LOCK0_BIT);
                end else if (i == int'(OFS_HW2)) begin
                    gen_q[i] <= gen_q[i] & (8'h01 << LOCK1_BIT);
                end else begin
                    gen_q[i] <= GEN_RESET;
                end
            end
        end else if (gen_wr) begin
            gen_q[addr[4:0]] <= wdata;
            if (addr == OFS_HW2) begin
                gen_q[addr[4:0]][LOCK1_BIT] <= wdata[LOCK1_BIT] | lock1;
            end
        end
    end

    // ----------------------------------------
    // Status flags and events
    // ----------------------------------------
    logic [1:0] wd_cnt_q;
    logic [8:0] rst_low_cnt_q;
    logic wd_trip;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            spi_fail_flag_o <= 1'b0;
        end else if (mode_wr && (stop_to_sleep
                || (stop_to_norm && (wdata[4:0] != mode_q[4:0])))) begin
            spi_fail_flag_o <= 1'b1;
        end else if (spi_fail_clear_i) begin
            spi_fail_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            main_supply_overvolt_flag_o <= 1'b0;
        end else if (overvolt_i) begin
            main_supply_overvolt_flag_o <= 1'b1;
        end else if (overvolt_flag_clear_i) begin
            main_supply_overvolt_flag_o <= 1'b0;
        end
    end

    assign wd_trip = wd_trigger_fail_i && (hw0_q[WD_CNT_BIT] || wd_cnt_q != 2'h0);

    always_ff @(posedge clk_i) begin
        if (srst_i || restart_entry_i) begin
            wd_cnt_q <= 2'h0;
        end else if (wd_trigger_fail_i && wd_cnt_q != 2'h3) begin
            wd_cnt_q <= wd_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            restart_request_o <= 1'b0;
        end else begin
            restart_request_o <= (overvolt_i && mode_q[OV_ACT_BIT]) || wd_trip;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rst_low_cnt_q <= 9'h000;
            reset_output_pin_n_o <= 1'b1;
        end else if (soft_rst && !hw0_q[SRST_CFG_BIT]) begin
            rst_low_cnt_q <= 9'(SOFT_RST_LOW_CYC - 1);
            reset_output_pin_n_o <= 1'b0;
        end else if (rst_low_cnt_q != 9'h000) begin
            rst_low_cnt_q <= rst_low_cnt_q - 9'h001;
        end else begin
            reset_output_pin_n_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic aux_on;

    always_comb begin
        case (mode_q[AUX_HI:AUX_LO])
            AUX_NORMAL: aux_on = mode_q[MODE_HI:MODE_LO] == SBCMSC_NORMAL;
            AUX_NORM_STOP: aux_on = mode_q[MODE_HI:MODE_LO] == SBCMSC_NORMAL
                || mode_q[MODE_HI:MODE_LO] == SBCMSC_STOP;
            AUX_ALWAYS: aux_on = !restart_active_i && !failsafe_active_i
                && (!init_active_i || dev_s_q[1]);
            default: aux_on = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chip_mode_o <= SBCMSC_NORMAL;
            main_supply_reset_threshold_o <= 2'h0;
            aux_supply_on_o <= 1'b0;
            fail_output_pin_o <= 1'b0;
            charge_pump_enable_o <= 1'b0;
        end else begin
            chip_mode_o <= mode_q[MODE_HI:MODE_LO];
            main_supply_reset_threshold_o <= mode_q[THR_HI:THR_LO];
            aux_supply_on_o <= aux_on;
            fail_output_pin_o <= fail_pin_is_fail_out_i
                && (hw0_q[FAIL_FORCE_BIT] || failure_flag_i);
            charge_pump_enable_o <= hw0_q[PUMP_EN_BIT];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ov_flag_set: assert property (@(posedge clk_i) disable iff (srst_i)
        overvolt_i |=> main_supply_overvolt_flag_o)
        else $error("overvoltage flag not set");
    chk_ov_action: assert property (@(posedge clk_i) disable iff (srst_i)
        (overvolt_i && mode_q[OV_ACT_BIT]) |=> restart_request_o)
        else $error("overvoltage action missing");
    chk_restart_mode: assert property (@(posedge clk_i) disable iff (srst_i)
        restart_entry_i |=> mode_q == ($past(mode_q) & MODE_RESTART_KEEP))
        else $error("restart value of mode register wrong");
    chk_restart_hw0: assert property (@(posedge clk_i) disable iff (srst_i)
        restart_entry_i |=> hw0_q == ($past(hw0_q) & HW0_RESTART_KEEP))
        else $error("restart value of hardware control wrong");
    chk_stop_sleep: assert property (@(posedge clk_i) disable iff (srst_i)
        (mode_wr && stop_to_sleep && !restart_entry_i && !overtemp_i) |=> $stable(mode_q))
        else $error("stop to sleep write accepted");
    chk_stop_norm: assert property (@(posedge clk_i) disable iff (srst_i)
        (mode_wr && stop_to_norm && !restart_entry_i && !overtemp_i)
        |=> mode_q[4:0] == $past(mode_q[4:0])
        && (spi_fail_flag_o || $past(wdata[4:0]) == $past(mode_q[4:0])))
        else $error("stop to normal write mishandled");
    chk_lock_cp: assert property (@(posedge clk_i) disable iff (srst_i)
        (lock0 && !restart_entry_i) |=> hw0_q[PUMP_EN_BIT] == $past(hw0_q[PUMP_EN_BIT]))
        else $error("locked charge pump enable changed");
    chk_soft_rst_pin: assert property (@(posedge clk_i) disable iff (srst_i)
        (soft_rst && !hw0_q[SRST_CFG_BIT] && !restart_entry_i)
        |=> !reset_output_pin_n_o [*8])
        else $error("reset output not held low");
    chk_reserved_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        !mode_q[5] && hw0_q[7] == 1'b0 && hw0_q[4:3] == 2'h0 && !hw0_q[1])
        else $error("reserved bit set");
    chk_sleep_flag: assert property (@(posedge clk_i) disable iff (srst_i)
        (mode_wr && stop_to_sleep) |=> spi_fail_flag_o)
        else $error("refused write did not flag serial error");
    chk_perm_lock: assert property (@(posedge clk_i) disable iff (srst_i)
        lock1 |=> lock1)
        else $error("permanent lock released");
    chk_restart_force: assert property (@(posedge clk_i) disable iff (srst_i)
        restart_entry_i |=> !hw0_q[FAIL_FORCE_BIT])
        else $error("force bit kept through restart");
    chk_overtemp_aux: assert property (@(posedge clk_i) disable iff (srst_i)
        overtemp_i |=> mode_q[AUX_HI:AUX_LO] == AUX_OFF)
        else $error("aux supply field not cleared");

endmodule

// ### verif/sbcmsc_spi_master.sv
// Serial port master model standing in for the microcontroller.
`timescale 1ns/1ps
module sbcmsc_spi_master (
    input wire logic clk_i,
    output logic spi_clk_o,
    output logic spi_sel_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i
);
    localparam int HALF = 6;

    initial begin
        spi_clk_o = 1'b1;
        spi_sel_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Sends one frame least significant bit first and returns its second byte.
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        spi_sel_n_o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            tick(HALF);
            spi_clk_o = 1'b0;
            spi_mosi_o = tx[i];
            tick(HALF);
            if (i >= 8) begin
                rx[i-8] = spi_miso_i;
            end
            spi_clk_o = 1'b1;
        end
        tick(HALF);
        spi_sel_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        tick(12);
    endtask
endmodule

// ### verif/tb_top.sv
// Self-checking testbench for the mode and supply control register bank.
`timescale 1ns/1ps
module tb_top;
    import sbcmsc_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic spi_clk, spi_sel_n, spi_mosi, spi_miso;
    logic dev_mode = 1'b0, restart_entry = 1'b0, overtemp = 1'b0, overvolt = 1'b0;
    logic ov_clear = 1'b0, failure_flag = 1'b0, fail_out_cfg = 1'b1, wd_fail = 1'b0;
    logic spi_clear = 1'b0;
    logic [2:0] st = 3'h0;
    logic [1:0] mode_o, thr_o;
    logic aux_on, ov_flag, req, spi_fail, rst_n, fail_pin, charge_pump_enable;
    logic [7:0] prev, v;
    int req_cnt = 0, low_cnt = 0, fail_count = 0, cmp_count = 0;

    always #25 clk_i = ~clk_i;

    sbcmsc_spi_master i_sbcmsc_spi_master (.clk_i(clk_i), .spi_clk_o(spi_clk),
        .spi_sel_n_o(spi_sel_n), .spi_mosi_o(spi_mosi), .spi_miso_i(spi_miso));

    sbcmsc_regs i_sbcmsc_regs (.clk_i(clk_i), .srst_i(srst_i), .spi_clk_i(spi_clk),
        .spi_sel_n_i(spi_sel_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
        .dev_mode_i(dev_mode), .restart_entry_i(restart_entry),
        .restart_active_i(st[2]), .failsafe_active_i(st[1]), .init_active_i(st[0]),
        .overtemp_i(overtemp), .overvolt_i(overvolt), .overvolt_flag_clear_i(ov_clear),
        .failure_flag_i(failure_flag), .fail_pin_is_fail_out_i(fail_out_cfg),
        .wd_trigger_fail_i(wd_fail), .spi_fail_clear_i(spi_clear), .chip_mode_o(mode_o),
        .main_supply_reset_threshold_o(thr_o), .aux_supply_on_o(aux_on),
        .main_supply_overvolt_flag_o(ov_flag), .restart_request_o(req),
        .spi_fail_flag_o(spi_fail), .reset_output_pin_n_o(rst_n),
        .fail_output_pin_o(fail_pin), .charge_pump_enable_o(charge_pump_enable));

    always @(posedge clk_i) begin
        if (req === 1'b1) begin
            req_cnt++;
        end
        if (rst_n === 1'b0) begin
            low_cnt++;
        end
    end

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chb(input string name, input logic exp, input logic got);
        chk(name, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        i_sbcmsc_spi_master.xfer({8'h00, 1'b0, a}, rx);
        chk("read data", exp, rx);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] old);
        logic [7:0] rx;
        i_sbcmsc_spi_master.xfer({d, 1'b1, a}, rx);
        chk("write echo", old, rx);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(3);
    endtask

    task automatic do_reset();
        srst_i = 1'b1;
        tick(3);
        srst_i = 1'b0;
        tick(6);
    endtask

    initial begin
        tick(100000);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        rd(OFS_MODE_SUPPLY, 8'h00);
        rd(OFS_HW0, 8'h00);
        rd(7'h05, 8'h00);
        chb("reset pin", 1'b1, rst_n);
        pulse(wd_fail);
        chk("restart requests", 8'h00, req_cnt[7:0]);
        pulse(wd_fail);
        chk("restart requests", 8'h01, req_cnt[7:0]);
        wr(OFS_HW0, 8'h01, 8'h00);
        pulse(restart_entry);
        pulse(wd_fail);
        chk("restart requests", 8'h02, req_cnt[7:0]);
        pulse(overvolt);
        chb("overvolt flag", 1'b1, ov_flag);
        chk("restart requests", 8'h02, req_cnt[7:0]);
        pulse(ov_clear);
        chb("overvolt flag", 1'b0, ov_flag);
        wr(OFS_MODE_SUPPLY, 8'h04, 8'h00);
        pulse(overvolt);
        chk("restart requests", 8'h03, req_cnt[7:0]);
        wr(OFS_MODE_SUPPLY, 8'h3F, 8'h04);
        rd(OFS_MODE_SUPPLY, 8'h1F);
        chk("threshold", 8'h03, {6'h00, thr_o});
        chb("aux on", 1'b1, aux_on);
        for (int i = 0; i < 3; i++) begin
            st = 3'h1 << i;
            tick(3);
            chb("aux on", 1'b0, aux_on);
        end
        st = 3'h0;
        prev = 8'h1F;
        for (int i = 0; i < 8; i++) begin
            v = {i[2], 2'h0, i[1:0], 3'h0};
            wr(OFS_MODE_SUPPLY, v, prev);
            chk("chip mode", {6'h00, i[2], 1'b0}, {6'h00, mode_o});
            chb("aux on", (i[1:0] != 2'h0) && (i[2:0] != 3'h5), aux_on);
            prev = v;
        end
        wr(OFS_MODE_SUPPLY, 8'h58, 8'h98);
        rd(OFS_MODE_SUPPLY, 8'h98);
        chb("serial error", 1'b1, spi_fail);
        pulse(spi_clear);
        chb("serial error", 1'b0, spi_fail);
        wr(OFS_MODE_SUPPLY, 8'h0B, 8'h98);
        rd(OFS_MODE_SUPPLY, 8'h18);
        chb("serial error", 1'b1, spi_fail);
        pulse(spi_clear);
        pulse(overtemp);
        rd(OFS_MODE_SUPPLY, 8'h00);
        wr(OFS_MODE_SUPPLY, 8'h9B, 8'h00);
        pulse(restart_entry);
        rd(OFS_MODE_SUPPLY, 8'h03);
        wr(OFS_HW0, 8'hFF, 8'h01);
        rd(OFS_HW0, 8'h65);
        chb("fail output", 1'b1, fail_pin);
        chb("charge pump", 1'b1, charge_pump_enable);
        fail_out_cfg = 1'b0;
        tick(3);
        chb("fail output", 1'b0, fail_pin);
        fail_out_cfg = 1'b1;
        pulse(restart_entry);
        rd(OFS_HW0, 8'h45);
        chb("fail output", 1'b0, fail_pin);
        failure_flag = 1'b1;
        wr(OFS_HW0, 8'h65, 8'h45);
        wr(OFS_HW0, 8'h00, 8'h65);
        chb("fail output", 1'b1, fail_pin);
        failure_flag = 1'b0;
        tick(3);
        chb("fail output", 1'b0, fail_pin);
        low_cnt = 0;
        wr(OFS_MODE_SUPPLY, 8'hC0, 8'h03);
        tick(250);
        chk("reset low cycles", 8'(SOFT_RST_LOW_CYC), low_cnt[7:0]);
        rd(OFS_MODE_SUPPLY, 8'h00);
        wr(OFS_HW0, 8'h45, 8'h00);
        wr(OFS_HW1, 8'h08, 8'h00);
        wr(OFS_HW2, 8'h01, 8'h00);
        low_cnt = 0;
        wr(OFS_MODE_SUPPLY, 8'hC0, 8'h00);
        tick(250);
        chk("reset low cycles", 8'h00, low_cnt[7:0]);
        rd(OFS_HW0, 8'h44);
        wr(OFS_HW0, 8'h00, 8'h44);
        rd(OFS_HW0, 8'h44);
        wr(OFS_HW1, 8'h00, 8'h08);
        wr(OFS_HW0, 8'h00, 8'h44);
        rd(OFS_HW0, 8'h40);
        chb("charge pump", 1'b0, charge_pump_enable);
        dev_mode = 1'b1;
        do_reset();
        rd(OFS_MODE_SUPPLY, 8'h18);
        st = 3'h1;
        tick(3);
        chb("aux on", 1'b1, aux_on);
        st = 3'h0;
        rd(OFS_HW2, 8'h00);
        wr(OFS_MODE_SUPPLY, 8'hC0, 8'h18);
        tick(250);
        rd(OFS_MODE_SUPPLY, 8'h00);
        stop_test();
    end
endmodule
